/* design/dq_precode_pair.sv */
// Differential quadrature precoder for one ganged channel pair
`timescale 1ns/1ns
module dq_precode_pair (
    input  wire logic       i_clk,     // Pattern bit clock
    input  wire logic       i_sys_rst, // Synchronous reset, high
    input  wire logic       i_init,    // Load initial state
    input  wire logic       i_en,      // Pair is being coded
    input  wire logic       i_a,       // In-phase source bit
    input  wire logic       i_b,       // Quadrature source bit
    output logic            o_i,       // Coded in-phase bit
    output logic            o_q,       // Coded quadrature bit
    output logic [1:0]      o_state    // Previous symbol state
);
    import pattern_sync_pkg::*;

    typedef struct packed {
        logic pi;
        logic pq;
    } pair_state_t;

    pair_state_t st;
    pair_state_t next_st;
    logic        diff;

    // Equal bits rotate on the own rail, unequal bits cross rails
    assign diff = i_a ^ i_b;
    assign o_i = (~diff & (i_a ^ st.pi)) | (diff & (i_b ^ st.pq));
    assign o_q = (~diff & (i_b ^ st.pq)) | (diff & (i_a ^ st.pi));
    assign o_state = {st.pi, st.pq};

    always_comb begin
        next_st = st;
        if (i_init) begin
            next_st = pair_state_t'(PC_INIT);
        end else if (i_en) begin
            next_st.pi = o_i;
            next_st.pq = o_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= pair_state_t'(PC_INIT);
        end else begin
            st <= next_st;
        end
    end
endmodule

/* design/pattern_sync_gating_precode.sv */
// Sequencing, sync pulse gating and precoder control
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module pattern_sync_gating_precode (
    input  wire logic                 i_clk,        // 20 MHz clock
    input  wire logic                 i_sys_rst,    // Sync reset, high
    input  wire logic [7:0]           i_addr,       // Register byte address
    input  wire logic [31:0]          i_wdata,      // Write data
    input  wire logic                 i_wr,         // Write strobe
    input  wire logic                 i_rd,         // Read strobe
    output logic      [31:0]          o_rdata,      // Read data, next cycle
    input  wire logic                 i_pat_start,  // Pattern start pulse
    input  wire logic                 i_burst_gate, // External burst gate pin
    input  wire logic [3:0]           i_data,       // Channel data bits
    output logic      [3:0]           o_data,       // Coded channel data
    output logic                      o_data_en,    // Data output enabled
    output logic                      o_sync        // Gating sync pulse
);
    import pattern_sync_pkg::*;

    typedef struct packed {
        logic             burst;
        logic [1:0]       gang;
        logic             lock;
        logic             pc_en;
        logic [2:0]       ptype;
        logic [31:0]      patlen;
        logic [15:0]      rowlen;
        logic [15:0]      nrows;
        logic [7:0]       nblk;
        logic [31:0]      wid;
        logic [31:0]      dly;
        calc_state_t      cs;
        logic [47:0]      ext;
        logic [39:0]      period;
        logic [39:0]      pos;
        logic             gate_m;
        logic             gate_s;
        logic [31:0]      rdata;
        logic [3:0]       data;
        logic             den;
        logic             sync;
    } ctl_state_t;

    ctl_state_t  st;
    ctl_state_t  next_st;

    logic [1:0]  lgn;
    logic        gang_on;
    logic        pc_a;
    logic        pc_b;
    logic        dpq;
    logic        burst_act;
    logic        pc_init;
    logic [47:0] align_bits;
    logic [47:0] ext_min;
    logic [47:0] plen;
    logic [39:0] blk_bits;
    logic [39:0] lim_g;
    logic [39:0] per_lim;
    logic [39:0] eff_wid;
    logic [39:0] eff_dly;
    logic [40:0] end_g;
    logic [1:0]  pa_out;
    logic [1:0]  pb_out;
    logic [1:0]  pa_state;
    logic [1:0]  pb_state;

    // Gang count as a shift: 1, 2 or 4 channels
    always_comb begin
        case (st.gang)
            GANG_TWO:  lgn = 2'h1;
            GANG_FOUR: lgn = 2'h2;
            default:   lgn = 2'h0;
        endcase
    end

    assign gang_on   = (st.gang == GANG_TWO) || (st.gang == GANG_FOUR);
    assign pc_a      = st.pc_en && gang_on;
    assign dpq       = gang_on && st.lock;
    assign pc_b      = pc_a && dpq;
    assign burst_act = st.burst && (st.ptype <= PT_BLOCK);

    assign align_bits = ALIGN_BITS << lgn;
    assign ext_min    = EXT_MIN_BITS << lgn;
    assign plen = (st.patlen == 32'h0) ? 48'h1 : {16'h0, st.patlen};
    assign blk_bits   = {24'h0, st.rowlen} * {24'h0, st.nrows}
                        * {32'h0, st.nblk};

    // Ceiling in steps of 8N bits; margin of 16 steps is 128N bits
    assign lim_g = (st.ptype == PT_BLOCK) ? BLK_MAX_G : MAX_G;
    always_comb begin
        per_lim = (st.period > MARGIN_G) ? st.period - MARGIN_G : 40'h0;
        if (per_lim > lim_g) begin
            per_lim = lim_g;
        end
        eff_wid = {8'h0, st.wid};
        if (eff_wid > per_lim) begin
            eff_wid = per_lim;
        end
        eff_dly = {8'h0, st.dly};
        if (eff_dly > per_lim) begin
            eff_dly = per_lim;
        end
    end

    assign end_g = {1'b0, eff_dly} + {1'b0, eff_wid};

    dq_precode_pair u_pair_a (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_init    (pc_init),
        .i_en      (pc_a),
        .i_a       (i_data[0]),
        .i_b       (i_data[1]),
        .o_i       (pa_out[0]),
        .o_q       (pa_out[1]),
        .o_state   (pa_state)
    );

    dq_precode_pair u_pair_b (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_init    (pc_init),
        .i_en      (pc_b),
        .i_a       (i_data[2]),
        .i_b       (i_data[3]),
        .o_i       (pb_out[0]),
        .o_q       (pb_out[1]),
        .o_state   (pb_state)
    );

    always_comb begin
        next_st = st;
        next_st.rdata = 32'h0;
        pc_init = 1'b0;
        next_st.gate_m = i_burst_gate;
        next_st.gate_s = st.gate_m;

        // Period calculation runs over one or more cycles after a control or length write
        case (st.cs)
            CS_LOAD: begin
                if (st.ptype == PT_BLOCK) begin
                    next_st.period = blk_bits >> (GRAN_LG + lgn);
                    next_st.cs = CS_IDLE;
                end else begin
                    next_st.ext = plen;
                    if (plen <= align_bits) begin
                        next_st.cs = CS_EXT;
                    end else begin
                        next_st.cs = CS_ALN;
                    end
                end
            end
            CS_EXT: begin
                if (st.ext < ext_min) begin
                    next_st.ext = st.ext + plen;
                end else begin
                    next_st.cs = CS_ALN;
                end
            end
            CS_ALN: begin
                // Doubling until divisible by 128N gives the LCM
                if ((st.ext & (align_bits - 48'h1)) != 48'h0) begin
                    next_st.ext = st.ext << 1;
                end else begin
                    next_st.period = 40'(st.ext >> (GRAN_LG + lgn));
                    next_st.cs = CS_IDLE;
                end
            end
            default: begin
                next_st.cs = CS_IDLE;
            end
        endcase

        if (i_wr) begin
            case (i_addr)
                ADDR_CTRL: begin
                    next_st.burst = i_wdata[CTRL_BURST];
                    next_st.gang = i_wdata[CTRL_GANG_LSB +: 2];
                    next_st.lock = i_wdata[CTRL_LOCK];
                    next_st.pc_en = i_wdata[CTRL_PC_EN];
                    next_st.ptype = i_wdata[CTRL_TYPE_LSB +: 3];
                    pc_init = i_wdata[CTRL_INIT];
                    next_st.cs = CS_LOAD;
                end
                ADDR_PATLEN: begin
                    next_st.patlen = i_wdata;
                    next_st.cs = CS_LOAD;
                end
                ADDR_ROWLEN: begin
                    next_st.rowlen = i_wdata[15:0];
                    next_st.cs = CS_LOAD;
                end
                ADDR_NROWS: begin
                    next_st.nrows = i_wdata[15:0];
                    next_st.cs = CS_LOAD;
                end
                ADDR_NBLK: begin
                    next_st.nblk = i_wdata[7:0];
                    next_st.cs = CS_LOAD;
                end
                ADDR_WIDTH: begin
                    next_st.wid = i_wdata;
                end
                ADDR_DELAY: begin
                    next_st.dly = i_wdata;
                end
                default: begin
                    next_st.cs = next_st.cs;
                end
            endcase
        end

        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL: begin
                    next_st.rdata[CTRL_BURST] = st.burst;
                    next_st.rdata[CTRL_GANG_LSB +: 2] = st.gang;
                    next_st.rdata[CTRL_LOCK] = st.lock;
                    next_st.rdata[CTRL_PC_EN] = st.pc_en;
                    next_st.rdata[CTRL_TYPE_LSB +: 3] = st.ptype;
                end
                ADDR_PATLEN: next_st.rdata = st.patlen;
                ADDR_ROWLEN: next_st.rdata = {16'h0, st.rowlen};
                ADDR_NROWS:  next_st.rdata = {16'h0, st.nrows};
                ADDR_NBLK:   next_st.rdata = {24'h0, st.nblk};
                ADDR_WIDTH:  next_st.rdata = eff_wid[31:0];
                ADDR_DELAY:  next_st.rdata = eff_dly[31:0];
                ADDR_STATUS: begin
                    next_st.rdata[ST_BUSY] = (st.cs != CS_IDLE);
                    next_st.rdata[ST_BURST] = burst_act;
                    next_st.rdata[ST_PC_ON] = pc_a;
                    next_st.rdata[ST_DPQ] = dpq;
                    next_st.rdata[ST_PC_LSB +: 4] = {pb_state, pa_state};
                end
                // Period above 32 bits reads saturated
                ADDR_PERIOD: begin
                    if (st.period[39:32] != 8'h0) begin
                        next_st.rdata = 32'hFFFF_FFFF;
                    end else begin
                        next_st.rdata = st.period[31:0];
                    end
                end
                default: next_st.rdata = 32'h0;
            endcase
        end

        // One count per 8N-bit step, restarted by the pattern start
        if (i_pat_start || (st.period == 40'h0)
                || (st.pos >= st.period - 40'h1)) begin
            next_st.pos = 40'h0;
        end else begin
            next_st.pos = st.pos + 40'h1;
        end
        next_st.sync = (st.pos >= eff_dly)
                       && ({1'b0, st.pos} < end_g);

        next_st.data[1:0] = pc_a ? pa_out : i_data[1:0];
        next_st.data[3:2] = pc_b ? pb_out : i_data[3:2];
        next_st.den = !burst_act || st.gate_s;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '0;
            st.patlen <= RST_PATLEN;
            st.rowlen <= RST_ROWLEN;
            st.nrows <= RST_NROWS;
            st.nblk <= RST_NBLK;
            st.wid <= RST_WIDTH;
            st.dly <= RST_DELAY;
            st.cs <= CS_LOAD;
            st.den <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_data = st.data;
    assign o_data_en = st.den;
    assign o_sync = st.sync;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    property p_pc_gang;
        pc_a |-> (st.gang != GANG_NONE);
    endproperty
    a_pc_gang: assert property (p_pc_gang)
        else $error("precoder active without ganging");

    property p_dpq;
        pc_b |-> (st.lock && pc_a);
    endproperty
    a_dpq: assert property (p_dpq)
        else $error("second pair coded outside DPQPSK");

    property p_init;
        pc_init |=> (pa_state == PC_INIT) && (pb_state == PC_INIT);
    endproperty
    a_init: assert property (p_init)
        else $error("precoder state not one after initialize");

    property p_joint;
        pc_a && (st.gang == GANG_TWO) && !st.lock
            |=> (o_data[3:2] == $past(i_data[3:2]));
    endproperty
    a_joint: assert property (p_joint)
        else $error("unpaired channels coded in DQPSK");

    property p_burst_type;
        burst_act |-> (st.ptype <= PT_BLOCK);
    endproperty
    a_burst_type: assert property (p_burst_type)
        else $error("burst on unsupported pattern type");

    property p_repeat;
        !burst_act |=> o_data_en;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat mode data gated off");

    property p_align;
        (st.cs == CS_ALN) && ((st.ext & (align_bits - 48'h1)) == 48'h0)
            && (st.ptype != PT_BLOCK)
            |-> ((st.ext >= ext_min) || (plen > align_bits))
            ##1 (st.period == $past(st.ext) >> (GRAN_LG + lgn));
    endproperty
    a_align: assert property (p_align)
        else $error("sync period not extended and aligned");

    property p_limit;
        (eff_wid <= lim_g) && (eff_dly <= lim_g);
    endproperty
    a_limit: assert property (p_limit)
        else $error("delay or width beyond ceiling");

    property p_zero_width;
        (eff_wid == 40'h0) |=> !o_sync;
    endproperty
    a_zero_width: assert property (p_zero_width)
        else $error("sync pulse with zero width");

    property p_rise;
        // Settings rewritten mid-period may open the window anywhere
        $rose(o_sync) && ($past(eff_dly, 2) == $past(eff_dly))
            && ($past(eff_wid, 2) == $past(eff_wid))
            |-> ($past(st.pos) == $past(eff_dly));
    endproperty
    a_rise: assert property (p_rise)
        else $error("sync pulse rose away from delay");

    c_sync: cover property ($rose(o_sync) ##[1:64] $fell(o_sync));
    c_burst_gate: cover property (burst_act && !o_data_en);
    c_dpq: cover property (pc_b ##1 pc_b);
    c_calc: cover property ((st.cs == CS_EXT) ##[1:64] (st.cs == CS_IDLE));
endmodule

/* shared/pattern_sync_pkg.sv */
// Constants and types for the sync gating and precoder block
// How it works
// - Precoder can only be active while channels are ganged.
// - Two ganged channels give DQPSK; adding lockstep gives DPQPSK.
// - Initialize loads the precoder state with the value one.
// - One precoder setting covers every ganged channel together; the code codes the second pair only with lockstep set.
// - Sequencing and sync settings are shared; length follows channel one.
// - Burst is allowed only for PRBS, zero run, user and block types.
// - Repeat mode outputs the pattern and data without a break.
// - Sync period is LCM of extended length and 128 times gang count.
// - Block pattern period is row length times rows times blocks.
// - Lengths up to 128N are multiplied until at least 512N.
// - Pulse width runs from zero to period minus 128N, 8N steps.
// - Delay from pattern start uses the same range and 8N steps.
// - Non-block delay and width stop at the documented bit ceiling.
// - Block delay and width stop at period minus 128N and ceiling.
package pattern_sync_pkg;

    localparam int DATA_W = 32;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PATLEN = 8'h04;
    localparam logic [7:0] ADDR_ROWLEN = 8'h08;
    localparam logic [7:0] ADDR_NROWS  = 8'h0C;
    localparam logic [7:0] ADDR_NBLK   = 8'h10;
    localparam logic [7:0] ADDR_WIDTH  = 8'h14;
    localparam logic [7:0] ADDR_DELAY  = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_PERIOD = 8'h20;

    localparam int CTRL_BURST    = 0;
    localparam int CTRL_GANG_LSB = 1;
    localparam int CTRL_LOCK     = 3;
    localparam int CTRL_PC_EN    = 4;
    localparam int CTRL_TYPE_LSB = 5;
    localparam int CTRL_INIT     = 8;

    localparam int ST_BUSY  = 0;
    localparam int ST_BURST = 1;
    localparam int ST_PC_ON = 2;
    localparam int ST_DPQ   = 3;
    localparam int ST_PC_LSB = 4;

    localparam logic [1:0] GANG_NONE = 2'h0;
    localparam logic [1:0] GANG_TWO  = 2'h1;
    localparam logic [1:0] GANG_FOUR = 2'h2;

    localparam logic [2:0] PT_PRBS     = 3'h0;
    localparam logic [2:0] PT_ZERO_RUN = 3'h1;
    localparam logic [2:0] PT_USER     = 3'h2;
    localparam logic [2:0] PT_BLOCK    = 3'h3;

    localparam logic [31:0] RST_PATLEN = 32'h0000_0080;
    localparam logic [15:0] RST_ROWLEN = 16'h0100;
    localparam logic [15:0] RST_NROWS  = 16'h0001;
    localparam logic [7:0]  RST_NBLK   = 8'h01;
    localparam logic [31:0] RST_WIDTH  = 32'h0000_0000;
    localparam logic [31:0] RST_DELAY  = 32'h0000_0000;
    localparam logic [1:0]  PC_INIT    = 2'h3;

    localparam logic [47:0] ALIGN_BITS   = 48'h0000_0000_0080;
    localparam logic [47:0] EXT_MIN_BITS = 48'h0000_0000_0200;
    localparam int          GRAN_LG      = 3;
    localparam logic [39:0] MARGIN_G     = 40'h00_0000_0010;
    localparam logic [39:0] MAX_BITS_1CH = 40'h07_FFFF_FF80;
    localparam logic [39:0] BLK_MAX_BITS = 40'h00_8FFF_FF80;
    localparam logic [39:0] MAX_G        = MAX_BITS_1CH >> GRAN_LG;
    localparam logic [39:0] BLK_MAX_G    = BLK_MAX_BITS >> GRAN_LG;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_LOAD = 2'b01,
        CS_EXT  = 2'b10,
        CS_ALN  = 2'b11
    } calc_state_t;

endpackage

/* test/pattern_sink.sv */
// Receiving-side model: counts sync pulses and cycles without data
`timescale 1ns/1ns
module pattern_sink (
    input  wire logic i_clk,     // Bit clock
    input  wire logic i_sys_rst, // Sync reset, high
    input  wire logic i_data_en, // Data valid from source
    input  wire logic i_sync,    // Gating sync pulse
    output int        o_rises,   // Sync rising edges seen
    output int        o_gaps     // Cycles without data
);
    logic last_sync;
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rises <= 0;
            o_gaps <= 0;
            last_sync <= 1'b0;
        end else begin
            if (i_sync && !last_sync)
                o_rises <= o_rises + 1;
            if (!i_data_en)
                o_gaps <= o_gaps + 1;
            last_sync <= i_sync;
        end
    end
endmodule

/* test/test_pattern_sync_gating_precode.sv */
// Self-checking bench for sync gating and precoder control
`timescale 1ns/1ns
module test_pattern_sync_gating_precode;
    import pattern_sync_pkg::*;
    localparam int SP = 64;
    localparam int SD = 2;
    localparam int SW = 3;
    logic        i_clk = 0;
    logic        i_sys_rst = 1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 0;
    logic        i_rd = 0;
    logic        i_pat_start = 0;
    logic        i_burst_gate = 1;
    logic [3:0]  i_data = 4'h0;
    logic [31:0] o_rdata;
    logic [3:0]  o_data;
    logic        o_data_en;
    logic        o_sync;
    int          rises;
    int          gaps;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          r0;
    int          g0;
    logic [31:0] seed = 32'h1598;
    logic [63:0] rq[$];
    logic [11:0] sq[$];
    logic        rd_seen = 0;
    logic        st_seen = 0;
    logic        strm = 0;
    logic        poll = 0;
    logic        en_exp = 1;
    logic        ip;
    logic        qp;
    logic        pcb = 0;
    logic        jp = 1;
    logic        kp = 1;

    pattern_sync_gating_precode dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pat_start(i_pat_start), .i_burst_gate(i_burst_gate),
        .i_data(i_data), .o_data(o_data), .o_data_en(o_data_en),
        .o_sync(o_sync));
    pattern_sink sink (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_data_en(o_data_en),
        .i_sync(o_sync), .o_rises(rises), .o_gaps(gaps));

    always #25 i_clk = ~i_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Independent period model: repeat short lengths, then align
    function automatic logic [31:0] exp_per(logic [31:0] len, int n);
        logic [47:0] s;
        logic [47:0] e;
        s = (len == 0) ? 48'h1 : 48'(len);
        e = s;
        if (s <= 48'(128 * n))
            while (e < 48'(512 * n))
                e = e + s;
        while (e % 48'(128 * n) != 0)
            e = e * 2;
        return 32'(e / 48'(8 * n));
    endfunction

    function automatic logic [31:0] cw(logic [1:0] g, bit lk, bit pc,
                                       logic [2:0] t, bit b);
        cw = 32'h0;
        cw[CTRL_GANG_LSB+:2] = g;
        cw[CTRL_LOCK] = lk;
        cw[CTRL_PC_EN] = pc;
        cw[CTRL_TYPE_LSB+:3] = t;
        cw[CTRL_BURST] = b;
    endfunction

    task automatic check(string nm, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e,
                      logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        rq.push_back({m, e & m});
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask

    // Period calculation length varies, so poll busy under a bound
    task automatic wait_idle();
        poll = 1;
        for (int k = 0; k < 200; k++) begin
            @(posedge i_clk);
            i_rd <= 1'b1;
            i_addr <= ADDR_STATUS;
            @(posedge i_clk);
            i_rd <= 1'b0;
            @(negedge i_clk);
            if (o_rdata[ST_BUSY] === 1'b0)
                break;
        end
        poll = 0;
        check("busy", 32'h0, 32'(o_rdata[ST_BUSY]));
    endtask

    // Drive random data; note expected data, sync and enable per cycle
    task automatic stream(int n, logic [5:0] m, bit pc, bit sy);
        logic [3:0] v;
        logic a;
        logic b;
        logic d;
        logic ii;
        logic qq;
        int c;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            v = 4'(xs());
            i_data <= v;
            strm <= 1'b1;
            i_pat_start <= (sy && i == 0);
            // Free-running pulses before the restart must not count
            if (sy && i == 3)
                r0 = rises;
            if (pc) begin
                a = v[0];
                b = v[1];
                d = a ^ b;
                ii = d ? (b ^ qp) : (a ^ ip);
                qq = d ? (a ^ ip) : (b ^ qp);
                ip = ii;
                qp = qq;
                v[1:0] = {qq, ii};
            end
            if (pc && pcb) begin
                a = v[2];
                b = v[3];
                d = a ^ b;
                ii = d ? (b ^ kp) : (a ^ jp);
                qq = d ? (a ^ jp) : (b ^ kp);
                jp = ii;
                kp = qq;
                v[3:2] = {qq, ii};
            end
            c = i - 1;
            sq.push_back({m & {1'b1, i >= 1, 4'hF},
                m & {en_exp, c >= 0 && c % SP >= SD && c % SP < SD + SW, v}});
        end
        @(posedge i_clk);
        i_data <= 4'h0;
        strm <= 1'b0;
        i_pat_start <= 1'b0;
        @(negedge i_clk);
    endtask

    always @(posedge i_clk) begin
        rd_seen <= i_rd & ~poll;
        st_seen <= strm;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            final_report();
        end
    end

    always @(negedge i_clk) begin
        logic [63:0] e;
        logic [11:0] s;
        if (rd_seen) begin
            e = rq.pop_front();
            check("rdata", e[31:0], o_rdata & e[63:32]);
        end
        if (st_seen) begin
            s = sq.pop_front();
            check("stream", 32'(s[5:0]),
                  32'({o_data_en, o_sync, o_data} & s[11:6]));
        end
    end

    initial begin
        logic [31:0] pl[4];
        logic [1:0]  gg[4];
        pl = '{32'h80, 32'h64, 32'h80, 32'hC8};
        gg = '{GANG_NONE, GANG_NONE, GANG_TWO, GANG_FOUR};
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_PATLEN, RST_PATLEN);
        rd(ADDR_ROWLEN, 32'(RST_ROWLEN));
        rd(ADDR_NROWS, 32'(RST_NROWS));
        rd(ADDR_NBLK, 32'(RST_NBLK));
        rd(ADDR_WIDTH, RST_WIDTH);
        rd(ADDR_DELAY, RST_DELAY);
        wr(8'h24, 32'h5A5A_5A5A);
        rd(8'h24, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CTRL, cw(gg[k], 0, 0, PT_PRBS, 0));
            wr(ADDR_PATLEN, pl[k]);
            wait_idle();
            rd(ADDR_PERIOD, exp_per(pl[k], 1 << gg[k]));
        end
        wr(ADDR_CTRL, cw(GANG_NONE, 0, 0, PT_BLOCK, 0));
        wr(ADDR_NROWS, 32'h2);
        wr(ADDR_NBLK, 32'h3);
        wait_idle();
        rd(ADDR_PERIOD, 32'h100 * 2 * 3 / 8);
        wr(ADDR_CTRL, cw(GANG_NONE, 0, 0, PT_USER, 0));
        wr(ADDR_PATLEN, 32'h80);
        wait_idle();
        rd(ADDR_PERIOD, SP);
        wr(ADDR_WIDTH, 32'hFFFF_FFFF);
        wr(ADDR_DELAY, 32'hFFFF_FFFF);
        rd(ADDR_WIDTH, SP - 16);
        rd(ADDR_DELAY, SP - 16);
        wr(ADDR_WIDTH, SW);
        wr(ADDR_DELAY, SD);
        g0 = gaps;
        stream(2 * SP + 2, 6'h3F, 0, 1);
        check("rises", 2, rises - r0);
        check("gaps", 0, gaps - g0);
        wr(ADDR_CTRL, cw(GANG_NONE, 0, 1, PT_PRBS, 0));
        rd(ADDR_STATUS, 32'h0, 32'h4);
        stream(16, 6'h0F, 0, 0);
        wr(ADDR_CTRL, cw(GANG_TWO, 0, 1, PT_PRBS, 0) | 32'h100);
        ip = 1'b1;
        qp = 1'b1;
        rd(ADDR_STATUS, 32'h34, 32'h3C);
        rd(ADDR_CTRL, cw(GANG_TWO, 0, 1, PT_PRBS, 0));
        stream(40, 6'h0F, 1, 0);
        rd(ADDR_STATUS, {ip, qp, 4'h4}, 32'h3C);
        wr(ADDR_CTRL, cw(GANG_TWO, 1, 1, PT_PRBS, 0));
        rd(ADDR_STATUS, 32'hC, 32'hC);
        pcb = 1'b1;
        stream(24, 6'h0F, 1, 0);
        rd(ADDR_STATUS, {jp, kp, ip, qp, 4'hC}, 32'hFC);
        pcb = 1'b0;
        for (int t = 0; t < 6; t++) begin
            wr(ADDR_CTRL, cw(GANG_NONE, 0, 0, 3'(t), 1));
            @(posedge i_clk);
            i_burst_gate <= 1'b0;
            repeat (4) @(posedge i_clk);
            en_exp = (t >= 4);
            rd(ADDR_STATUS, 32'(t < 4) << ST_BURST, 32'h2);
            stream(3, 6'h20, 0, 0);
            @(posedge i_clk);
            i_burst_gate <= 1'b1;
            repeat (4) @(posedge i_clk);
            en_exp = 1'b1;
            stream(3, 6'h20, 0, 0);
        end
        repeat (4) @(posedge i_clk);
        final_report();
    end
endmodule
